// ===== hw/ttp_pkg.sv
package ttp_pkg;

    // ------------------------------------------------------------
    // Register selects and layout
    // ------------------------------------------------------------
    localparam logic [1:0] ADDR_TX_CODE = 2'h0;
    localparam logic [1:0] ADDR_RX_CODE = 2'h1;
    localparam logic [1:0] ADDR_CONTROL = 2'h2;
    localparam logic [1:0] ADDR_STATUS  = 2'h3;
    localparam logic       SEL_CODE     = 1'h0;
    localparam logic       SEL_CTRL     = 1'h1;
    localparam logic       DIR_WRITE    = 1'h0;
    localparam logic       BUS_SEPARATE = 1'h1;

    localparam int CTRL_PROGRESS_ON = 3;
    localparam int CTRL_FAST_DETECT = 2;
    localparam int CTRL_DET_ENABLE  = 1;
    localparam int CTRL_TONE_TX_ON  = 0;

    localparam logic [3:0] TX_CODE_RST = 4'h0;
    localparam logic [3:0] CONTROL_RST = 4'h0;
    localparam logic [3:0] RX_CODE_RST = 4'h0;
    localparam logic [3:0] DATA_IDLE   = 4'h0;

    // ------------------------------------------------------------
    // Receive timing, microseconds, normal and fast
    // ------------------------------------------------------------
    localparam int CLK_MHZ          = 100;
    localparam int DELAY_NORM_US    = 41000;
    localparam int DELAY_FAST_US    = 26000;
    localparam int HOLD_NORM_US     = 28000;
    localparam int HOLD_FAST_US     = 20000;
    localparam int DROP1_NORM_US    = 400;
    localparam int DROP1_FAST_US    = 400;
    localparam int FLAG_DELAY_US    = 600;
    localparam int CNT_W            = 24;

    typedef enum logic [1:0] {
        TTP_RX_IDLE    = 2'b00,
        TTP_RX_QUALIFY = 2'b01,
        TTP_RX_PRESENT = 2'b11,
        TTP_RX_VALID   = 2'b10
    } ttp_rx_e;

endpackage

// ===== hw/ttp_host_port.sv
`timescale 1ns/1ns
// Functional notes
// - Four 4-bit registers: transmit code, received code, control, status.
// - Transmit code and control are write-only; received code and status read-only.
// - Bus type pin high gives separate strobes, low gives shared strobe.
// - Separate mode: write strobe rising edge with chip select low stores data.
// - Separate mode: chip select and read strobe low drive addressed register.
// - Shared mode: strobe falling edge, direction low, writes selected register.
// - Shared mode: strobe rising edge, direction high, latches select, drives data.
// - Power-down high holds transmit code and control in reset.
// - Address 00/01/10/11 in separate mode; select plus direction in shared mode.
// - Control and status bit layout, code registers hold tone code.
// - Gaps up to first drop-out tolerance before flag do not abort detection.
// - Gaps shorter than the detect hold time during flag keep flag and code.
// - Received code presented only after detect delay from tone start.
// - Flag and code withdrawn detect hold time after tone disappears.
// - Flag falls a flag delay after the code is presented.
// - Fast detect bit selects the fast set of receive timings.
// - New-detect flag set on any detector rising, cleared by status read.
// - Valid-tone flag reads 0 while a tone is received, else 1.
module ttp_host_port #(
    parameter logic [ttp_pkg::CNT_W-1:0] DELAY_NORM_CYC =
        ttp_pkg::CNT_W'(ttp_pkg::DELAY_NORM_US * ttp_pkg::CLK_MHZ),
    parameter logic [ttp_pkg::CNT_W-1:0] DELAY_FAST_CYC =
        ttp_pkg::CNT_W'(ttp_pkg::DELAY_FAST_US * ttp_pkg::CLK_MHZ),
    parameter logic [ttp_pkg::CNT_W-1:0] HOLD_NORM_CYC =
        ttp_pkg::CNT_W'(ttp_pkg::HOLD_NORM_US * ttp_pkg::CLK_MHZ),
    parameter logic [ttp_pkg::CNT_W-1:0] HOLD_FAST_CYC =
        ttp_pkg::CNT_W'(ttp_pkg::HOLD_FAST_US * ttp_pkg::CLK_MHZ),
    parameter logic [ttp_pkg::CNT_W-1:0] DROP1_NORM_CYC =
        ttp_pkg::CNT_W'(ttp_pkg::DROP1_NORM_US * ttp_pkg::CLK_MHZ),
    parameter logic [ttp_pkg::CNT_W-1:0] DROP1_FAST_CYC =
        ttp_pkg::CNT_W'(ttp_pkg::DROP1_FAST_US * ttp_pkg::CLK_MHZ),
    parameter logic [ttp_pkg::CNT_W-1:0] FLAG_DELAY_CYC =
        ttp_pkg::CNT_W'(ttp_pkg::FLAG_DELAY_US * ttp_pkg::CLK_MHZ)
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Host bus pins
    input  wire logic       bus_type_select,
    input  wire logic       chip_select_n,
    input  wire logic       write_strobe_or_direction,
    input  wire logic       read_strobe_or_shared_strobe,
    input  wire logic       addr_latch_en,
    input  wire logic [3:0] data_in,
    output logic      [3:0] data_out,
    output logic            data_oe_n,
    input  wire logic       power_down_pin,
    // Detector side
    input  wire logic       tone_present,
    input  wire logic [3:0] tone_code_in,
    input  wire logic       fax_tone_in,
    input  wire logic       progress_tone_in,
    // Register contents toward the tone logic
    output logic      [3:0] tone_code_transmit,
    output logic            progress_tone_output_on,
    output logic            fast_detect_select,
    output logic            detector_outputs_enable,
    output logic            tone_transmit_on,
    output logic            valid_tone_flag_n
);

    // ------------------------------------------------------------
    // Pin sampling and edges
    // ------------------------------------------------------------
    logic       cs_n_ff;
    logic       wr_ff;
    logic       rd_ff;
    logic       ale_ff;
    logic [3:0] din_ff;
    logic       wr_prev_ff;
    logic       rd_prev_ff;
    logic       ale_prev_ff;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cs_n_ff     <= 1'b1;
            wr_ff       <= 1'b1;
            rd_ff       <= 1'b1;
            ale_ff      <= 1'b0;
            din_ff      <= ttp_pkg::DATA_IDLE;
            wr_prev_ff  <= 1'b1;
            rd_prev_ff  <= 1'b1;
            ale_prev_ff <= 1'b0;
        end
        else
        begin
            cs_n_ff     <= chip_select_n;
            wr_ff       <= write_strobe_or_direction;
            rd_ff       <= read_strobe_or_shared_strobe;
            ale_ff      <= addr_latch_en;
            din_ff      <= data_in;
            wr_prev_ff  <= wr_ff;
            rd_prev_ff  <= rd_ff;
            ale_prev_ff <= ale_ff;
        end
    end

    logic sep_mode;
    logic wr_rise;
    logic rd_rise;
    logic rd_fall;
    logic sep_write;
    logic sh_write;
    logic sh_rd_start;
    assign sep_mode    = (bus_type_select == ttp_pkg::BUS_SEPARATE);
    assign wr_rise     = wr_ff && !wr_prev_ff;
    assign rd_rise     = rd_ff && !rd_prev_ff;
    assign rd_fall     = !rd_ff && rd_prev_ff;
    assign sep_write   = sep_mode && !cs_n_ff && wr_rise;
    assign sh_write    = !sep_mode && !cs_n_ff && rd_fall
                         && (wr_ff == ttp_pkg::DIR_WRITE);
    assign sh_rd_start = !sep_mode && !cs_n_ff && rd_rise
                         && (wr_ff != ttp_pkg::DIR_WRITE);

    // ------------------------------------------------------------
    // Address latch
    // ------------------------------------------------------------
    logic [1:0] addr_ff;
    logic       sel_ff;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            addr_ff <= ttp_pkg::ADDR_TX_CODE;
        else if (sep_mode && ale_prev_ff && !ale_ff)
            addr_ff <= din_ff[1:0];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            sel_ff <= ttp_pkg::SEL_CODE;
        else if (sh_rd_start)
            sel_ff <= ale_ff;
    end

    logic wr_sel_tx;
    logic wr_sel_ctl;
    assign wr_sel_tx  = (sep_write && addr_ff == ttp_pkg::ADDR_TX_CODE)
                        || (sh_write && ale_ff == ttp_pkg::SEL_CODE);
    assign wr_sel_ctl = (sep_write && addr_ff == ttp_pkg::ADDR_CONTROL)
                        || (sh_write && ale_ff == ttp_pkg::SEL_CTRL);

    // ------------------------------------------------------------
    // Write-only registers
    // ------------------------------------------------------------
    logic [3:0] tx_code_ff;
    logic [3:0] ctrl_ff;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tx_code_ff <= ttp_pkg::TX_CODE_RST;
        else if (power_down_pin)
            tx_code_ff <= ttp_pkg::TX_CODE_RST;
        else if (wr_sel_tx)
            tx_code_ff <= din_ff;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl_ff <= ttp_pkg::CONTROL_RST;
        else if (power_down_pin)
            ctrl_ff <= ttp_pkg::CONTROL_RST;
        else if (wr_sel_ctl)
            ctrl_ff <= din_ff;
    end

    assign tone_code_transmit      = tx_code_ff;
    assign progress_tone_output_on = ctrl_ff[ttp_pkg::CTRL_PROGRESS_ON];
    assign fast_detect_select      = ctrl_ff[ttp_pkg::CTRL_FAST_DETECT];
    assign detector_outputs_enable = ctrl_ff[ttp_pkg::CTRL_DET_ENABLE];
    assign tone_transmit_on        = ctrl_ff[ttp_pkg::CTRL_TONE_TX_ON];

    // ------------------------------------------------------------
    // Receive timing
    // ------------------------------------------------------------
    ttp_pkg::ttp_rx_e              rx_st_ff;
    logic [ttp_pkg::CNT_W-1:0]     on_cnt_ff;
    logic [ttp_pkg::CNT_W-1:0]     off_cnt_ff;
    logic [3:0]                    rx_code_ff;
    logic                          flag_n_ff;
    logic [ttp_pkg::CNT_W-1:0]     delay_cyc;
    logic [ttp_pkg::CNT_W-1:0]     hold_cyc;
    logic [ttp_pkg::CNT_W-1:0]     drop1_cyc;

    assign delay_cyc = fast_detect_select ? DELAY_FAST_CYC : DELAY_NORM_CYC;
    assign hold_cyc  = fast_detect_select ? HOLD_FAST_CYC : HOLD_NORM_CYC;
    assign drop1_cyc = fast_detect_select ? DROP1_FAST_CYC : DROP1_NORM_CYC;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_st_ff   <= ttp_pkg::TTP_RX_IDLE;
            on_cnt_ff  <= '0;
            off_cnt_ff <= '0;
            rx_code_ff <= ttp_pkg::RX_CODE_RST;
            flag_n_ff  <= 1'b1;
        end
        else
        begin
            off_cnt_ff <= tone_present ? '0 : off_cnt_ff + 1'b1;
            on_cnt_ff  <= on_cnt_ff + 1'b1;
            case (rx_st_ff)
                ttp_pkg::TTP_RX_IDLE:
                begin
                    on_cnt_ff <= '0;
                    if (tone_present)
                        rx_st_ff <= ttp_pkg::TTP_RX_QUALIFY;
                end
                ttp_pkg::TTP_RX_QUALIFY:
                begin
                    if (!tone_present && off_cnt_ff >= drop1_cyc)
                        rx_st_ff <= ttp_pkg::TTP_RX_IDLE;
                    else if (on_cnt_ff >= delay_cyc - 1'b1)
                    begin
                        rx_st_ff   <= ttp_pkg::TTP_RX_PRESENT;
                        rx_code_ff <= tone_code_in;
                        on_cnt_ff  <= '0;
                    end
                end
                ttp_pkg::TTP_RX_PRESENT:
                begin
                    if (on_cnt_ff >= FLAG_DELAY_CYC - 1'b1)
                    begin
                        rx_st_ff  <= ttp_pkg::TTP_RX_VALID;
                        flag_n_ff <= 1'b0;
                    end
                end
                ttp_pkg::TTP_RX_VALID:
                begin
                    // Short gaps fall well inside the hold count
                    if (!tone_present && off_cnt_ff >= hold_cyc - 1'b1)
                    begin
                        rx_st_ff   <= ttp_pkg::TTP_RX_IDLE;
                        rx_code_ff <= ttp_pkg::RX_CODE_RST;
                        flag_n_ff  <= 1'b1;
                    end
                end
                default:
                begin
                    rx_st_ff  <= ttp_pkg::TTP_RX_IDLE;
                    flag_n_ff <= 1'b1;
                end
            endcase
        end
    end

    assign valid_tone_flag_n = flag_n_ff;

    // ------------------------------------------------------------
    // Status and new-detect flag
    // ------------------------------------------------------------
    logic       fax_ok;
    logic       prog_ok;
    logic       fax_prev_ff;
    logic       prog_prev_ff;
    logic       flag_prev_ff;
    logic       new_det_ff;
    logic       stat_rd_ff;
    logic       stat_rd_end;
    logic       det_event;
    logic [3:0] status_val;

    assign prog_ok = detector_outputs_enable && progress_tone_in;
    assign fax_ok  = detector_outputs_enable && fax_tone_in && !progress_tone_in;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fax_prev_ff  <= 1'b0;
            prog_prev_ff <= 1'b0;
            flag_prev_ff <= 1'b1;
        end
        else
        begin
            fax_prev_ff  <= fax_ok;
            prog_prev_ff <= prog_ok;
            flag_prev_ff <= flag_n_ff;
        end
    end

    assign det_event = (fax_ok && !fax_prev_ff) || (prog_ok && !prog_prev_ff)
                       || (!flag_n_ff && flag_prev_ff);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            new_det_ff <= 1'b0;
        else if (det_event)
            new_det_ff <= 1'b1;
        else if (stat_rd_end)
            new_det_ff <= 1'b0;
    end

    assign status_val = {flag_n_ff, fax_ok, prog_ok, new_det_ff};

    // ------------------------------------------------------------
    // Read drive
    // ------------------------------------------------------------
    logic       rd_active;
    logic       rd_is_stat;
    logic [3:0] dout_ff;
    logic       oe_n_ff;

    assign rd_active  = sep_mode ? (!cs_n_ff && !rd_ff && addr_ff[0])
                        : (!cs_n_ff && rd_ff && wr_ff != ttp_pkg::DIR_WRITE
                           && !rd_rise);
    assign rd_is_stat = sep_mode ? (addr_ff == ttp_pkg::ADDR_STATUS)
                        : (sel_ff == ttp_pkg::SEL_CTRL);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            stat_rd_ff <= 1'b0;
        else
            stat_rd_ff <= rd_active && rd_is_stat;
    end

    assign stat_rd_end = stat_rd_ff && !(rd_active && rd_is_stat);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dout_ff <= ttp_pkg::DATA_IDLE;
            oe_n_ff <= 1'b1;
        end
        else if (rd_active)
        begin
            dout_ff <= rd_is_stat ? status_val : rx_code_ff;
            oe_n_ff <= 1'b0;
        end
        else
        begin
            dout_ff <= ttp_pkg::DATA_IDLE;
            oe_n_ff <= 1'b1;
        end
    end

    assign data_out  = dout_ff;
    assign data_oe_n = oe_n_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_pd_holds_regs: assert property (@(posedge clk) disable iff (rst)
        power_down_pin |=> (tx_code_ff == ttp_pkg::TX_CODE_RST
                            && ctrl_ff == ttp_pkg::CONTROL_RST))
        else $error("power-down did not clear write-only registers");

    a_sep_write_tx: assert property (@(posedge clk) disable iff (rst)
        (sep_write && addr_ff == ttp_pkg::ADDR_TX_CODE && !power_down_pin)
        |=> tx_code_ff == $past(din_ff))
        else $error("separate mode write missed transmit code");

    a_sh_write_ctl: assert property (@(posedge clk) disable iff (rst)
        (sh_write && ale_ff == ttp_pkg::SEL_CTRL && !power_down_pin)
        |=> ctrl_ff == $past(din_ff))
        else $error("shared mode write missed control");

    a_bus_released: assert property (@(posedge clk) disable iff (rst)
        cs_n_ff |=> data_oe_n)
        else $error("data driven without chip select");

    a_sep_read_drive: assert property (@(posedge clk) disable iff (rst)
        (sep_mode && !cs_n_ff && !rd_ff && addr_ff == ttp_pkg::ADDR_RX_CODE)
        |=> (!data_oe_n && data_out == $past(rx_code_ff)))
        else $error("separate read did not drive received code");

    a_flag_after_code: assert property (@(posedge clk) disable iff (rst)
        $fell(flag_n_ff) |-> $past(rx_st_ff) == ttp_pkg::TTP_RX_PRESENT
                             && $stable(rx_code_ff))
        else $error("flag fell without code presented first");

    a_new_det_set: assert property (@(posedge clk) disable iff (rst)
        $fell(flag_n_ff) |=> new_det_ff)
        else $error("new-detect not set on flag fall");

    a_status_clear: assert property (@(posedge clk) disable iff (rst)
        (stat_rd_end && !det_event) |=> !new_det_ff)
        else $error("status read did not clear new-detect");

    a_hold_release: assert property (@(posedge clk) disable iff (rst)
        $rose(flag_n_ff) |-> ($past(off_cnt_ff) >= hold_cyc - 1'b1
                              && rx_code_ff == ttp_pkg::RX_CODE_RST))
        else $error("flag withdrawn before hold time");

    a_no_tx_readback: assert property (@(posedge clk) disable iff (rst)
        (sep_mode && !cs_n_ff && !rd_ff && !addr_ff[0]) |=> data_oe_n)
        else $error("write-only register driven on read");

endmodule

// ===== bench/ttp_host_model.sv
`timescale 1ns/1ns
module ttp_host_model (
    // Clock and bus mode
    input  wire logic       clk,
    input  wire logic       sep_mode,
    // Device read path
    input  wire logic [3:0] data_out,
    input  wire logic       data_oe_n,
    // Host pins
    output logic            cs_n,
    output logic            wr,
    output logic            rd,
    output logic            ale,
    output logic      [3:0] data_in
);
    logic       host_oe_n = 1'h1;
    logic [3:0] host_d    = 4'h0;
    logic [3:0] last_d    = 4'h0;

    // Undriven lines show a changing pattern
    assign data_in = !host_oe_n ? host_d : (!data_oe_n ? data_out : ~last_d);

    always @(posedge clk)
        last_d <= data_in;

    initial
    begin
        cs_n = 1'h1;
        wr   = 1'h1;
        rd   = 1'h1;
        ale  = 1'h0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic idle();
        wait_n(1);
        rd = sep_mode;
        wait_n(3);
    endtask

    task automatic latch_addr(input logic [1:0] a);
        host_oe_n = 1'h0;
        host_d    = {2'h0, a};
        ale       = 1'h1;
        wait_n(3);
        ale = 1'h0;
        wait_n(3);
    endtask

    task automatic write_reg(input logic [1:0] a, input logic [3:0] d);
        if (sep_mode)
            latch_addr(a);
        host_oe_n = 1'h0;
        host_d    = d;
        ale       = sep_mode ? 1'h0 : a[1];
        wr        = sep_mode;
        cs_n      = 1'h0;
        wait_n(3);
        if (sep_mode)
            wr = 1'h0;
        else
            rd = 1'h1;
        wait_n(3);
        if (sep_mode)
            wr = 1'h1;
        else
            rd = 1'h0;
        wait_n(3);
        cs_n      = 1'h1;
        host_oe_n = 1'h1;
        wr        = 1'h1;
        wait_n(3);
    endtask

    task automatic read_reg(input logic [1:0] a, output logic [3:0] d, output logic oe_n);
        if (sep_mode)
            latch_addr(a);
        ale       = sep_mode ? 1'h0 : a[1];
        host_oe_n = 1'h1;
        wr        = 1'h1;
        cs_n      = 1'h0;
        wait_n(3);
        rd = !sep_mode;
        wait_n(5);
        d    = data_in;
        oe_n = data_oe_n;
        rd   = sep_mode;
        wait_n(3);
        cs_n = 1'h1;
        wait_n(3);
    endtask
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;

    // ------------------------------------------------------------
    // Shortened receive timing
    // ------------------------------------------------------------
    localparam int DLY_N = 40;
    localparam int DLY_F = 30;
    localparam int HLD_N = 25;
    localparam int HLD_F = 20;
    localparam int DRP   = 4;
    localparam int FLG   = 6;

    logic       clk  = 1'h0;
    logic       rst  = 1'h1;
    logic       sep  = 1'h1;
    logic       pd   = 1'h0;
    logic       tone = 1'h0;
    logic       fax  = 1'h0;
    logic       prog = 1'h0;
    logic [3:0] code = 4'h0;
    logic       cs_n, wr, rd, ale, oe_n, flag_n;
    logic       prog_on, fast_on, det_on, tx_on;
    logic [3:0] d_in, d_out, tx_code, ctrl;
    int         mismatches = 0;
    int         n_tests    = 0;
    int         cyc        = 0;
    int         t0;

    assign ctrl = {prog_on, fast_on, det_on, tx_on};

    always #5 clk = ~clk;

    always @(posedge clk)
        cyc <= cyc + 1;

    ttp_host_port #(
        .DELAY_NORM_CYC (24'(DLY_N)),
        .DELAY_FAST_CYC (24'(DLY_F)),
        .HOLD_NORM_CYC  (24'(HLD_N)),
        .HOLD_FAST_CYC  (24'(HLD_F)),
        .DROP1_NORM_CYC (24'(DRP)),
        .DROP1_FAST_CYC (24'(DRP)),
        .FLAG_DELAY_CYC (24'(FLG))
    ) i_ttp_host_port (
        .clk                          (clk),
        .rst                          (rst),
        .bus_type_select              (sep),
        .chip_select_n                (cs_n),
        .write_strobe_or_direction    (wr),
        .read_strobe_or_shared_strobe (rd),
        .addr_latch_en                (ale),
        .data_in                      (d_in),
        .data_out                     (d_out),
        .data_oe_n                    (oe_n),
        .power_down_pin               (pd),
        .tone_present                 (tone),
        .tone_code_in                 (code),
        .fax_tone_in                  (fax),
        .progress_tone_in             (prog),
        .tone_code_transmit           (tx_code),
        .progress_tone_output_on      (prog_on),
        .fast_detect_select           (fast_on),
        .detector_outputs_enable      (det_on),
        .tone_transmit_on             (tx_on),
        .valid_tone_flag_n            (flag_n)
    );

    ttp_host_model i_ttp_host_model (
        .clk       (clk),
        .sep_mode  (sep),
        .data_out  (d_out),
        .data_oe_n (oe_n),
        .cs_n      (cs_n),
        .wr        (wr),
        .rd        (rd),
        .ale       (ale),
        .data_in   (d_in)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_span(input string what, input int lo, input int hi, input int got);
        n_tests++;
        if (got < lo || got > hi)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic wr_reg(input logic [1:0] a, input logic [3:0] d);
        i_ttp_host_model.write_reg(a, d);
    endtask

    task automatic rd_chk(input string what, input logic [1:0] a, input logic [3:0] exp);
        logic [3:0] d;
        logic       o;
        i_ttp_host_model.read_reg(a, d, o);
        check({what, " drive"}, 4'h0, {3'h0, o});
        check(what, exp, d);
        check({what, " float"}, 4'h1, {3'h0, oe_n});
    endtask

    task automatic rd_none(input string what, input logic [1:0] a);
        logic [3:0] d;
        logic       o;
        i_ttp_host_model.read_reg(a, d, o);
        check(what, 4'h1, {3'h0, o});
    endtask

    task automatic wait_flag(input logic lvl);
        int n = 0;
        while (flag_n !== lvl && n < 400)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check("reset oe", 4'h1, {3'h0, oe_n});
        check("reset tx", 4'h0, tx_code);
        check("reset ctrl", 4'h0, ctrl);
        check("reset flag", 4'h1, {3'h0, flag_n});
    endtask

    task automatic t_sep_regs();
        wr_reg(ttp_pkg::ADDR_TX_CODE, 4'hA);
        wr_reg(ttp_pkg::ADDR_CONTROL, 4'h5);
        check("sep tx", 4'hA, tx_code);
        check("sep ctrl", 4'h5, ctrl);
        wr_reg(ttp_pkg::ADDR_RX_CODE, 4'hF);
        wr_reg(ttp_pkg::ADDR_STATUS, 4'hF);
        check("tx kept", 4'hA, tx_code);
        check("ctrl kept", 4'h5, ctrl);
        rd_none("tx hidden", ttp_pkg::ADDR_TX_CODE);
        rd_none("ctrl hidden", ttp_pkg::ADDR_CONTROL);
        rd_chk("sep rx", ttp_pkg::ADDR_RX_CODE, 4'h0);
        rd_chk("sep status", ttp_pkg::ADDR_STATUS, 4'h8);
    endtask

    task automatic t_power_down();
        pd = 1'h1;
        wait_n(4);
        check("pd tx", 4'h0, tx_code);
        check("pd ctrl", 4'h0, ctrl);
        wr_reg(ttp_pkg::ADDR_TX_CODE, 4'h3);
        check("pd write", 4'h0, tx_code);
        pd = 1'h0;
        wait_n(4);
    endtask

    task automatic t_shared_regs();
        sep = 1'h0;
        i_ttp_host_model.idle();
        wr_reg(ttp_pkg::ADDR_TX_CODE, 4'h6);
        wr_reg(ttp_pkg::ADDR_CONTROL, 4'h2);
        check("shr tx", 4'h6, tx_code);
        check("shr ctrl", 4'h2, ctrl);
        rd_chk("shr status", ttp_pkg::ADDR_STATUS, 4'h8);
    endtask

    task automatic t_rx_normal();
        t0   = cyc;
        code = 4'h9;
        tone = 1'h1;
        rd_chk("rx early", ttp_pkg::ADDR_RX_CODE, 4'h0);
        tone = 1'h0;
        wait_n(DRP - 1);
        tone = 1'h1;
        wait_flag(1'h0);
        check_span("flag fall", DLY_N + FLG - 2, DLY_N + FLG + 12, cyc - t0);
        rd_chk("rx code", ttp_pkg::ADDR_RX_CODE, 4'h9);
        rd_chk("status new", ttp_pkg::ADDR_STATUS, 4'h1);
        rd_chk("status clear", ttp_pkg::ADDR_STATUS, 4'h0);
        tone = 1'h0;
        wait_n(HLD_N - 10);
        tone = 1'h1;
        wait_n(5);
        check("gap flag", 4'h0, {3'h0, flag_n});
        rd_chk("gap code", ttp_pkg::ADDR_RX_CODE, 4'h9);
        t0   = cyc;
        tone = 1'h0;
        wait_flag(1'h1);
        check_span("flag rise", HLD_N - 2, HLD_N + 8, cyc - t0);
        rd_chk("code gone", ttp_pkg::ADDR_RX_CODE, 4'h0);
    endtask

    task automatic t_status_bits();
        fax = 1'h1;
        wait_n(4);
        rd_chk("fax", ttp_pkg::ADDR_STATUS, 4'hD);
        prog = 1'h1;
        wait_n(4);
        rd_chk("progress", ttp_pkg::ADDR_STATUS, 4'hB);
        fax  = 1'h0;
        prog = 1'h0;
        wr_reg(ttp_pkg::ADDR_CONTROL, 4'h0);
        fax = 1'h1;
        wait_n(4);
        rd_chk("fax masked", ttp_pkg::ADDR_STATUS, 4'h8);
        fax = 1'h0;
    endtask

    task automatic t_rx_fast();
        wr_reg(ttp_pkg::ADDR_CONTROL, 4'h4);
        check("fast bit", 4'h4, ctrl);
        t0   = cyc;
        code = 4'h5;
        tone = 1'h1;
        wait_flag(1'h0);
        check_span("fast fall", DLY_F + FLG - 2, DLY_F + FLG + 6, cyc - t0);
        rd_chk("fast code", ttp_pkg::ADDR_RX_CODE, 4'h5);
        t0   = cyc;
        tone = 1'h0;
        wait_flag(1'h1);
        check_span("fast rise", HLD_F - 2, HLD_F + 4, cyc - t0);
    endtask

    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        wait_n(6);
        rst = 1'h0;
        wait_n(1);
        t_reset();
        t_sep_regs();
        t_power_down();
        t_shared_regs();
        t_rx_normal();
        t_status_bits();
        t_rx_fast();
        end_sim();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_sim();
    end
endmodule
